// [rtl/dsiru_unpack.sv]
// dsi pixel unpacker, command decoder and reply composer with pixel fifo
// ****************************************************************
// pixel fifo
// ****************************************************************
module dsiru_fifo
   import dsiru_pkg::*;
#(
   parameter int W = PIX_W,
   parameter int D = FIFO_DEPTH
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0] wp;
   logic [AW:0] rp;
   logic full;
   logic empty;

   assign empty = wp == rp;
   assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem[rp[AW-1:0]];

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         wp <= '0;
         rp <= '0;
      end
      else
      begin
         if (inValid && !full)
         begin
            mem[wp[AW-1:0]] <= inData;
            wp <= wp + 1'b1;
         end
         if (outReady && !empty)
            rp <= rp + 1'b1;
      end
   end

   property p_no_overrun;
      @(posedge ref_clk) disable iff (reset)
      full && !(outReady && !empty) |=> wp == $past(wp);
   endproperty
   a_no_overrun: assert property (p_no_overrun)
      else $error("fifo written while full");
endmodule

// ****************************************************************
// unpacker top
// ****************************************************************
module dsiru_unpack
   import dsiru_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic linkClk,
   input wire logic linkData,
   input wire logic linkActive,
   input wire logic [1:0] vcId,
   input wire logic [7:0] phyErr,
   input wire logic protoErr,
   input wire logic btaIn,
   output logic cmdValid,
   output logic readReq,
   output logic [5:0] cmdDt,
   output logic [15:0] cmdParam,
   input wire logic [15:0] readData,
   input wire logic readTwo,
   input wire logic readLong,
   output logic pixValid,
   input wire logic pixReady,
   output dsiru_pix_type pixData,
   output logic fillReady,
   output logic pixDrop,
   output logic respValid,
   input wire logic respReady,
   output logic [7:0] respByte,
   output logic respTrig,
   output logic respLast,
   output logic btaOut,
   output logic [15:0] errReport
);
   dsiru_state_type st;
   dsiru_state_type next_st;
   logic [15:0] newErr;
   logic [7:0] rxByte;
   logic byteStb;
   logic [23:0] fixed;
   logic [5:0] syn;
   logic hit;
   logic single;
   logic multi;
   logic [5:0] dt;
   logic [15:0] pErr;
   logic [7:0] bv;
   logic launch;
   logic rdOk;
   logic [23:0] hs;
   logic [23:0] hl;
   logic [23:0] hr;
   logic [15:0] rcrc;
   logic [7:0] d1;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   function automatic logic [7:0] eccOf(input logic [23:0] d);
      logic [7:0] e;
      e = '0;
      for (int k = 0; k < 6; k++)
         e[k] = ^(d & ECC_MASK[k]);
      return e;
   endfunction

   // reflected form of x16+x12+x5+1, bits fed lsb first
   function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c;
      for (int b = 0; b < 8; b++)
         x = (x[0] ^ d[b]) ? ((x >> 1) ^ CRC_POLY_REV) : (x >> 1); // R23
      return x;
   endfunction

   assign launch = (st.rs == RS_IDLE) && btaIn; // R8
   assign rdOk = st.readPend && ((st.errReg & ERR_NO_READ) == '0); // R10 R13 R15 R16

   always_comb
   begin
      next_st = st;
      next_st.s1 = {linkActive, linkData, linkClk};
      next_st.s2 = st.s1;
      next_st.clkPrev = st.s2[0];
      next_st.actPrev = st.s2[2];
      next_st.cmdValid = 1'b0;
      next_st.readReq = 1'b0;
      next_st.pixPush = 1'b0;
      newErr = {8'h00, phyErr};
      newErr[ERR_PROTO] = protoErr;
      rxByte = {st.s2[1], st.sh[7:1]}; // R3
      byteStb = 1'b0;
      syn = '0;
      hit = 1'b0;
      fixed = st.hdr;
      single = 1'b0;
      multi = 1'b0;
      dt = '0;
      pErr = '0;
      bv = '0;
      if (st.s2[2] && !st.actPrev)
      begin
         next_st.txErr = '0;
         next_st.rx = RX_HDR;
         next_st.hIdx = '0;
         next_st.bitCnt = '0;
      end
      else if (!st.s2[2] && st.actPrev)
      begin
         // frame ended inside a packet
         if (st.rx != RX_SKIP && (st.rx != RX_HDR || st.hIdx != '0 || st.bitCnt != '0))
            newErr[ERR_LEN] = 1'b1;
         next_st.rx = RX_HDR;
         next_st.hIdx = '0;
         next_st.bitCnt = '0;
      end
      else if (st.s2[2] && st.s2[0] && !st.clkPrev)
      begin
         next_st.sh = rxByte;
         next_st.bitCnt = st.bitCnt + 3'h1;
         byteStb = st.bitCnt == 3'h7;
      end
      if (byteStb)
      begin
         case (st.rx)
            RX_HDR:
            begin
               if (st.hIdx != 2'h3)
               begin
                  next_st.hdr[8*st.hIdx +: 8] = rxByte;
                  next_st.hIdx = st.hIdx + 2'h1;
               end
               else
               begin
                  next_st.hIdx = '0;
                  syn = rxByte[5:0] ^ 6'(eccOf(st.hdr));
                  for (int i = 0; i < 24; i++)
                  begin
                     if (syn != '0 && syn == {ECC_MASK[5][i], ECC_MASK[4][i], ECC_MASK[3][i],
                                              ECC_MASK[2][i], ECC_MASK[1][i], ECC_MASK[0][i]})
                     begin
                        fixed[i] = !st.hdr[i];
                        hit = 1'b1;
                     end
                  end
                  single = (syn != '0) && (hit || $onehot(syn));
                  multi = (syn != '0) && !single;
                  dt = fixed[5:0];
                  pErr[ERR_ECC1] = single; // R22
                  pErr[ERR_ECC2] = multi;
                  pErr[ERR_VC] = !multi && (fixed[7:6] != vcId);
                  pErr[ERR_TYPE] = !multi && !DT_KNOWN[dt];
                  newErr = newErr | pErr;
                  if (multi || !DT_KNOWN[dt])
                     next_st.rx = RX_SKIP; // length cannot be trusted
                  else if (DT_LONG[dt])
                  begin
                     next_st.wc = fixed[23:8]; // R4
                     next_st.crc = CRC_INIT;
                     next_st.comp = '0;
                     next_st.loose = dt == DT_LOOSE18;
                     next_st.pixOn = !pErr[ERR_VC] && (dt == DT_LOOSE18 || dt == DT_RGB24);
                     next_st.rx = (fixed[23:8] == '0) ? RX_CRC : RX_PAY;
                  end
                  else if (((st.txErr | newErr) & ERR_NO_EXEC) == '0 && dt != DT_EOT)
                  begin
                     next_st.cmdDt = dt; // R12 R14 R15
                     next_st.cmdParam = fixed[23:8];
                     if (DT_READ[dt])
                     begin
                        next_st.readReq = 1'b1;
                        next_st.readPend = 1'b1;
                     end
                     else
                        next_st.cmdValid = 1'b1;
                  end
               end
            end
            RX_PAY:
            begin
               next_st.crc = crcByte(st.crc, rxByte);
               next_st.wc = st.wc - 16'h1;
               bv = st.loose ? {rxByte[7:2], 2'b00} : rxByte; // R1
               if (st.pixOn)
               begin
                  // red, green, blue, one byte each
                  next_st.comp = (st.comp == 2'h2) ? 2'h0 : st.comp + 2'h1; // R2
                  if (st.comp == 2'h0)
                     next_st.pr = bv;
                  else if (st.comp == 2'h1)
                     next_st.pg = bv;
                  else
                  begin
                     next_st.pix = '{r: st.pr, g: st.pg, b: bv};
                     next_st.pixPush = 1'b1;
                  end
               end
               if (st.wc == 16'h1)
               begin
                  next_st.rx = RX_CRC;
                  next_st.hIdx = '0;
               end
            end
            RX_CRC:
            begin
               if (st.hIdx == 2'h0)
               begin
                  next_st.crcLo = rxByte;
                  next_st.hIdx = 2'h1;
               end
               else
               begin
                  newErr[ERR_CRC] = {rxByte, st.crcLo} != st.crc; // R23
                  next_st.rx = RX_HDR;
                  next_st.hIdx = '0;
               end
            end
            RX_SKIP:
               next_st.rx = RX_SKIP;
            default:
               next_st.rx = RX_HDR;
         endcase
      end
      next_st.txErr = next_st.txErr | newErr;
      // a detection in the clearing cycle survives into the next report
      next_st.errReg = (launch ? ERR_RESET : st.errReg) | newErr; // R17 R24
      d1 = readTwo ? readData[15:8] : 8'h00; // R20
      hs = {d1, readData[7:0], vcId, readTwo ? DT_SHORT_READ2 : DT_SHORT_READ1};
      hl = {LONG_READ_WC, vcId, DT_LONG_READ}; // R18
      hr = {st.errReg, vcId, DT_ERR_RPT}; // R21
      rcrc = crcByte(crcByte(CRC_INIT, readData[7:0]), readData[15:8]);
      case (st.rs)
         RS_IDLE:
         begin
            if (launch)
            begin
               next_st.rs = RS_SEND;
               next_st.readPend = 1'b0;
               next_st.respTrig = 1'b0;
               if (rdOk)
               begin
                  // read data first, report after it in the same transmission
                  if (readLong)
                     next_st.respBuf = {eccOf(hr), hr, rcrc, readData, eccOf(hl), hl};
                  else
                     next_st.respBuf = {32'h0, eccOf(hr), hr, eccOf(hs), hs}; // R10 R11
                  next_st.respLeft = (readLong ? 4'h8 : SHORT_BYTES) +
                     ((st.errReg != '0) ? SHORT_BYTES : 4'h0);
               end
               else if (st.errReg != '0)
               begin
                  next_st.respBuf = {64'h0, eccOf(hr), hr}; // R12 R13 R14 R15 R16
                  next_st.respLeft = SHORT_BYTES;
               end
               else
               begin
                  next_st.respBuf = {88'h0, ACK_TRIGGER}; // R7 R9 R19
                  next_st.respLeft = 4'h1;
                  next_st.respTrig = 1'b1;
               end
            end
         end
         RS_SEND:
         begin
            if (respReady)
            begin
               next_st.respBuf = st.respBuf >> 8;
               next_st.respLeft = st.respLeft - 4'h1;
               if (st.respLeft == 4'h1)
                  next_st.rs = RS_TURN;
            end
         end
         RS_TURN:
         begin
            next_st.rs = RS_IDLE; // R6
            next_st.respTrig = 1'b0;
         end
         default:
            next_st.rs = RS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         st <= '0;
         st.rx <= RX_HDR;
         st.rs <= RS_IDLE;
         st.errReg <= ERR_RESET;
      end
      else
         st <= next_st;
   end

   dsiru_fifo #(.W(PIX_W), .D(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .inValid(st.pixPush),
      .inReady(fillReady),
      .inData(st.pix),
      .outValid(pixValid),
      .outReady(pixReady),
      .outData(pixData)
   );

   assign pixDrop = st.pixPush && !fillReady;
   assign cmdValid = st.cmdValid;
   assign readReq = st.readReq;
   assign cmdDt = st.cmdDt;
   assign cmdParam = st.cmdParam;
   assign respValid = st.rs == RS_SEND;
   assign respByte = st.respBuf[7:0];
   assign respTrig = st.respTrig;
   assign respLast = (st.rs == RS_SEND) && (st.respLeft == 4'h1);
   assign btaOut = st.rs == RS_TURN;
   assign errReport = st.errReg;

   property p_ack_byte;
      respValid && respTrig |-> respByte == ACK_TRIGGER && respLast;
   endproperty
   a_ack_byte: assert property (p_ack_byte) // R19
      else $error("acknowledge trigger byte wrong");
   property p_turn;
      respLast && respReady |=> btaOut ##1 !btaOut && !respValid;
   endproperty
   a_turn: assert property (p_turn) // R6
      else $error("no turnaround after reply");
   property p_silent;
      !respValid && !btaIn |=> !respValid;
   endproperty
   a_silent: assert property (p_silent) // R8
      else $error("reply without turnaround request");
   property p_clean_ack;
      launch && !st.readPend && st.errReg == '0 |=> respValid && respTrig;
   endproperty
   a_clean_ack: assert property (p_clean_ack) // R7
      else $error("clean transmission not acknowledged");
   // second byte only moves on once the first was taken
   property p_report;
      launch && st.errReg != '0 && !rdOk |=> respByte[5:0] == DT_ERR_RPT ##1
      (!$past(respReady) || respByte == $past(errReport[7:0], 2));
   endproperty
   a_report: assert property (p_report) // R21
      else $error("error report layout wrong");
   property p_clear;
      launch && newErr == '0 |=> errReport == '0;
   endproperty
   a_clear: assert property (p_clear) // R17
      else $error("error flags not cleared after report");
   property p_sticky;
      !launch |=> (errReport & $past(errReport)) == $past(errReport);
   endproperty
   a_sticky: assert property (p_sticky) // R24
      else $error("error flag lost before report");
   property p_no_exec;
      cmdValid || readReq |-> (st.txErr & ERR_NO_EXEC) == '0;
   endproperty
   a_no_exec: assert property (p_no_exec) // R14
      else $error("command executed despite fatal error");
   property p_loose;
      st.pixPush && st.loose |-> st.pix.r[1:0] == 2'b00 && st.pix.g[1:0] == 2'b00 &&
         st.pix.b[1:0] == 2'b00;
   endproperty
   a_loose: assert property (p_loose) // R1
      else $error("loose pixel low bits not dropped");
endmodule

// [pkg/dsiru_pkg.sv]
// shared constants and types of the dsi pixel unpacker and reply composer
// Contract
// R1: loose 18-bit components taken from bits 7:2
// R2: 24-bit pixels are red, green, blue bytes
// R3: each component arrives least significant bit first
// R4: long packet: id, count, ecc, payload, checksum
// R5: host sends line lengths in multiples of three
// R6: turn bus around after every reply
// R7: acknowledge only when nothing erred since last reply
// R8: no reply without host turnaround request
// R9: clean non-read command answered with acknowledge
// R10: clean read request answered with read data
// R11: single-bit read: data then error report
// R12: single-bit command executes, then error report
// R13: multi-bit read: error report only, no data
// R14: multi-bit command not executed, error report sent
// R15: fatal errors: report only, no access at all
// R16: sync or checksum errors: report, no read data
// R17: reported error flags cleared from error register
// R18: reply types 0x02, 0x08, 0x1C; replies here use 0x02, 0x1C, 0x21, 0x22, never 0x08
// R19: acknowledge trigger byte 00100001 in wire order
// R20: short read: id, two data, ecc; pad zero
// R21: error report: id, bits 0-7, 8-15, ecc
// R22: error bits 0-13 one per detected error
// R23: payload crc x16+x12+x5+1, empty gives 0xFFFF
// R24: error flags sticky until next reply reports them
package dsiru_pkg;
   localparam logic [5:0] DT_LOOSE18 = 6'h2E;
   localparam logic [5:0] DT_RGB24 = 6'h3E;
   localparam logic [5:0] DT_ERR_RPT = 6'h02;
   localparam logic [5:0] DT_EOT = 6'h08;
   localparam logic [5:0] DT_LONG_READ = 6'h1C;
   localparam logic [5:0] DT_SHORT_READ1 = 6'h21;
   localparam logic [5:0] DT_SHORT_READ2 = 6'h22;
   localparam logic [63:0] DT_KNOWN = 64'h4286_421E_423E_437E;
   localparam logic [63:0] DT_READ = 64'h0000_0010_0010_0050;
   localparam logic [63:0] DT_LONG = 64'h4200_4200_4200_4200;
   localparam logic [7:0] ACK_TRIGGER = 8'h84;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY_REV = 16'h8408;
   localparam logic [15:0] LONG_READ_WC = 16'h0002;
   localparam logic [5:0][23:0] ECC_MASK =
      {24'hEFFC00, 24'hDF03F0, 24'hB8E38E, 24'h749A6D, 24'hF2555B, 24'hF12CB7};
   localparam int ERR_ECC1 = 8;
   localparam int ERR_ECC2 = 9;
   localparam int ERR_CRC = 10;
   localparam int ERR_TYPE = 11;
   localparam int ERR_VC = 12;
   localparam int ERR_LEN = 13;
   localparam int ERR_PROTO = 15;
   localparam logic [15:0] ERR_NO_EXEC = 16'h9A03;
   localparam logic [15:0] ERR_NO_READ = 16'h9E17;
   localparam logic [15:0] ERR_RESET = 16'h0000;
   localparam logic [3:0] SHORT_BYTES = 4'h4;
   localparam int PIX_W = 24;
   localparam int FIFO_DEPTH = 8;

   typedef enum logic [3:0] {
      RX_HDR = 4'b0001,
      RX_PAY = 4'b0010,
      RX_CRC = 4'b0100,
      RX_SKIP = 4'b1000
   } dsiru_rx_type;

   typedef enum logic [2:0] {
      RS_IDLE = 3'b001,
      RS_SEND = 3'b010,
      RS_TURN = 3'b100
   } dsiru_rs_type;

   typedef struct packed {
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } dsiru_pix_type;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic clkPrev;
      logic actPrev;
      dsiru_rx_type rx;
      logic [1:0] hIdx;
      logic [2:0] bitCnt;
      logic [7:0] sh;
      logic [23:0] hdr;
      logic [15:0] wc;
      logic [15:0] crc;
      logic [7:0] crcLo;
      logic [1:0] comp;
      logic [7:0] pr;
      logic [7:0] pg;
      logic loose;
      logic pixOn;
      logic [15:0] txErr;
      logic [15:0] errReg;
      logic readPend;
      logic cmdValid;
      logic [5:0] cmdDt;
      logic [15:0] cmdParam;
      logic readReq;
      logic pixPush;
      dsiru_pix_type pix;
      dsiru_rs_type rs;
      logic [95:0] respBuf;
      logic [3:0] respLeft;
      logic respTrig;
   } dsiru_state_type;
endpackage

// [dv/dsiru_host_model.sv]
// host transmitter model that serialises packets onto the link
module dsiru_host_model
   import dsiru_pkg::*;
(
   output logic linkClk,
   output logic linkData,
   output logic linkActive
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // link driver
   // ****************************************************************
   initial
   begin
      linkClk = 1'b0;
      linkData = 1'b0;
      linkActive = 1'b0;
   end

   function automatic logic [7:0] ecc(input logic [23:0] h);
      logic [7:0] e;
      e = 8'h00;
      for (int i = 0; i < 6; i++)
         e[i] = ^(h & ECC_MASK[i]);
      return e;
   endfunction

   function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
      for (int i = 0; i < 8; i++)
         c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      return c;
   endfunction

   // clock stands low between frames; a released data line shows the inverse
   task automatic send(input logic [7:0] q[$]);
      linkActive = 1'b1;
      #100;
      foreach (q[k])
         for (int i = 0; i < 8; i++)
         begin
            linkData = q[k][i];
            #80 linkClk = 1'b1;
            #80 linkClk = 1'b0;
         end
      #100 linkActive = 1'b0;
      linkData = ~linkData;
   endtask
endmodule

// [dv/dsi_peripheral_response_unpack_test.sv]
// self-checking bench of the unpacker against a queue-based reference
`define CHK(n, e, g) \
   begin \
      check_count++; \
      if ((e) !== (g)) \
      begin \
         n_errors++; \
         $display("mismatch %s expected %h seen %h", n, e, g); \
      end \
   end

module dsi_peripheral_response_unpack_test
   import dsiru_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [1:0] VC = 2'h1;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic protoErr = 1'b0, btaIn = 1'b0, readTwo = 1'b0, readLong = 1'b0;
   logic pixReady = 1'b0, respReady = 1'b0, drain = 1'b0;
   logic linkClk, linkData, linkActive, cmdValid, readReq, pixValid, fillReady, pixDrop;
   logic respValid, respTrig, respLast, btaOut;
   logic [1:0] vcId = VC;
   logic [7:0] phyErr = 8'h00;
   logic [7:0] respByte;
   logic [5:0] cmdDt, eDt;
   logic [15:0] readData = 16'h0000;
   logic [15:0] cmdParam, errReport, eP;
   logic [15:0] mErr = 16'h0000;
   logic [15:0] rnd = 16'hB4FE;
   dsiru_pix_type pixData;
   dsiru_pix_type pq[$];
   logic [9:0] eq[$];
   logic [9:0] got[$];
   logic [7:0] pk[$];
   int n_errors = 0;
   int check_count = 0;
   int nCmd = 0;
   int nRd = 0;
   int nDrop = 0;

   always #5 ref_clk = ~ref_clk;

   dsiru_host_model host (.linkClk(linkClk), .linkData(linkData), .linkActive(linkActive));

   dsiru_unpack uut (.ref_clk(ref_clk), .reset(reset), .linkClk(linkClk),
      .linkData(linkData), .linkActive(linkActive), .vcId(vcId), .phyErr(phyErr),
      .protoErr(protoErr), .btaIn(btaIn), .cmdValid(cmdValid), .readReq(readReq),
      .cmdDt(cmdDt), .cmdParam(cmdParam), .readData(readData), .readTwo(readTwo),
      .readLong(readLong), .pixValid(pixValid), .pixReady(pixReady), .pixData(pixData),
      .fillReady(fillReady), .pixDrop(pixDrop), .respValid(respValid),
      .respReady(respReady), .respByte(respByte), .respTrig(respTrig),
      .respLast(respLast), .btaOut(btaOut), .errReport(errReport));

   // ****************************************************************
   // reference model
   // ****************************************************************
   function automatic logic [7:0] rb();
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      return rnd[7:0];
   endfunction

   task automatic report_and_stop();
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic fail_if(input logic c);
      if (c)
      begin
         n_errors++;
         report_and_stop();
      end
   endtask

   task automatic put4(input logic [23:0] h, input logic [23:0] f);
      for (int i = 0; i < 3; i++)
         pk.push_back(h[8*i +: 8] ^ f[8*i +: 8]);
      pk.push_back(host.ecc(h));
   endtask

   task automatic exp4(input logic [23:0] h);
      for (int i = 0; i < 3; i++)
         eq.push_back({2'b00, h[8*i +: 8]});
      eq.push_back({2'b00, host.ecc(h)});
   endtask

   task automatic cmd(input logic [5:0] dt, input logic [23:0] f);
      eDt = dt;
      eP = {8'h00, rb()};
      put4({eP, VC, dt}, f);
   endtask

   task automatic put_long(input logic [5:0] dt, input int n, input logic bad);
      logic [15:0] c;
      logic [7:0] b [3];
      c = CRC_INIT;
      put4({n[15:0], VC, dt}, 24'h0);
      for (int i = 0; i < n; i++)
      begin
         b[i % 3] = rb();
         pk.push_back(b[i % 3]);
         c = host.crc(c, b[i % 3]);
         if (i % 3 == 2 && (drain || pq.size() < 8))
            pq.push_back(dt == DT_RGB24 ? {b[0], b[1], b[2]} :
               {b[0] & 8'hFC, b[1] & 8'hFC, b[2] & 8'hFC});
      end
      c = bad ? ~c : c;
      pk.push_back(c[7:0]);
      pk.push_back(c[15:8]);
   endtask

   task automatic model_reply(input logic rd);
      logic [15:0] c;
      logic [7:0] d0, d1;
      logic [7:0] lb [4];
      d0 = readData[7:0];
      d1 = readTwo ? readData[15:8] : 8'h00;
      if (rd && (mErr & ERR_NO_READ) == 16'h0000)
      begin
         if (readLong)
         begin
            exp4({16'h0002, VC, 6'h1C});
            c = host.crc(host.crc(CRC_INIT, d0), d1);
            lb = '{d0, d1, c[7:0], c[15:8]};
            foreach (lb[i])
               eq.push_back({2'b00, lb[i]});
         end
         else
            exp4({d1, d0, VC, readTwo ? 6'h22 : 6'h21});
      end
      if (mErr != 16'h0000)
         exp4({mErr, VC, 6'h02});
      // 00100001 in wire order, lsb first
      if (eq.size() == 0)
         eq.push_back({2'b10, 8'b10000100});
      eq[eq.size() - 1][8] = 1'b1;
      mErr = 16'h0000;
   endtask

   // ****************************************************************
   // monitor and transaction runner
   // ****************************************************************
   always @(posedge ref_clk)
   begin
      pixReady <= drain & rnd[3];
      respReady <= rnd[5] | rnd[2];
      void'(rb());
      if (reset === 1'b0)
      begin
         nCmd += (cmdValid === 1'b1);
         nRd += (readReq === 1'b1);
         nDrop += (pixDrop === 1'b1);
         if (respValid === 1'b1 && respReady === 1'b1)
            got.push_back({respTrig, respLast, respByte});
         if (pixValid === 1'b1 && pixReady === 1'b1)
         begin
            `CHK("pixel", (pq.size() > 0 ? pq[0] : 24'h0), pixData)
            if (pq.size() > 0)
               void'(pq.pop_front());
         end
      end
   end

   task automatic run(input logic bta, input logic [15:0] fErr, input int kind, input logic inj);
      int c0;
      int r0;
      int i;
      c0 = nCmd;
      r0 = nRd;
      fork
         host.send(pk);
         if (inj)
         begin
            repeat (40) @(posedge ref_clk);
            phyErr <= 8'h01;
            protoErr <= 1'b1;
            @(posedge ref_clk);
            phyErr <= 8'h00;
            protoErr <= 1'b0;
         end
      join
      pk.delete();
      repeat (20) @(negedge ref_clk);
      mErr |= fErr;
      `CHK("cmdCount", c0 + (kind == 1), nCmd)
      `CHK("readCount", r0 + (kind == 2), nRd)
      `CHK("errReport", mErr, errReport)
      if (kind != 0)
         `CHK("command", ({eDt, eP}), ({cmdDt, cmdParam}))
      if (bta)
      begin
         model_reply(kind == 2);
         @(posedge ref_clk);
         btaIn <= 1'b1;
         @(posedge ref_clk);
         btaIn <= 1'b0;
         for (i = 0; i < 300 && btaOut !== 1'b1; i++)
            @(negedge ref_clk);
         fail_if(i == 300);
         repeat (3) @(negedge ref_clk);
         `CHK("replyLength", eq.size(), got.size())
         foreach (eq[j])
            `CHK("replyByte", eq[j], got[j])
         `CHK("errCleared", 16'h0000, errReport)
         eq.delete();
         got.delete();
      end
      else
      begin
         repeat (30) @(negedge ref_clk);
         `CHK("noReply", 0, got.size())
      end
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      int k;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (5) @(negedge ref_clk);
      `CHK("idle", 18'h0, ({respValid, btaOut, errReport}))
      drain = 1'b1;
      cmd(6'h15, 24'h0);
      run(1'b1, 16'h0, 1, 1'b0);
      put_long(DT_RGB24, 6, 1'b0);
      put_long(DT_LOOSE18, 6, 1'b0);
      run(1'b0, 16'h0, 0, 1'b0);
      drain = 1'b0;
      put_long(DT_RGB24, 30, 1'b0);
      run(1'b0, 16'h0, 0, 1'b0);
      `CHK("fifoFull", 2'b01, ({fillReady, pixValid}))
      `CHK("pixDrop", 2, nDrop)
      drain = 1'b1;
      for (k = 0; k < 500 && pq.size() > 0; k++)
         @(negedge ref_clk);
      fail_if(k == 500);
      put_long(DT_RGB24, 3, 1'b1);
      run(1'b0, 16'h0400, 0, 1'b0);
      cmd(6'h14, 24'h0);
      run(1'b1, 16'h0, 2, 1'b0);
      for (k = 0; k < 3; k++)
      begin
         @(posedge ref_clk);
         readTwo <= k != 0;
         readLong <= k == 2;
         readData <= {rb(), rb()};
         cmd(k == 1 ? 6'h24 : 6'h14, 24'h0);
         run(1'b1, 16'h0, 2, 1'b0);
      end
      cmd(6'h14, 24'h000008);
      run(1'b1, 16'h0100, 2, 1'b0);
      cmd(6'h15, 24'h010000);
      run(1'b1, 16'h0100, 1, 1'b0);
      cmd(6'h14, 24'h000300);
      run(1'b1, 16'h0200, 0, 1'b0);
      cmd(6'h15, 24'h000300);
      run(1'b1, 16'h0200, 0, 1'b0);
      cmd(6'h0F, 24'h0);
      run(1'b1, 16'h0800, 0, 1'b0);
      @(posedge ref_clk);
      vcId <= 2'h2;
      cmd(6'h15, 24'h0);
      run(1'b0, 16'h1000, 0, 1'b0);
      @(posedge ref_clk);
      vcId <= VC;
      put_long(DT_RGB24, 3, 1'b1);
      run(1'b0, 16'h0400, 0, 1'b0);
      cmd(6'h15, 24'h0);
      run(1'b1, 16'h8001, 0, 1'b1);
      report_and_stop();
   end
endmodule
